// file: tcm_consts.vh
// constants for the 16-bit compare-output timer block
`ifndef TCM_CONSTS_VH
`define TCM_CONSTS_VH
`define TCM_WGM_NORMAL 4'h0
`define TCM_WGM_CTC_A 4'h4
`define TCM_WGM_CTC_CAP 4'hc
`define TCM_COM_NONE 2'h0
`define TCM_COM_TOGGLE 2'h1
`define TCM_COM_CLEAR 2'h2
`define TCM_COM_SET 2'h3
`define TCM_CNT_MAX 16'hffff
`define TCM_CNT_BOTTOM 16'h0000
`define TCM_CS_STOP 3'h0
`define TCM_CS_DIV1 3'h1
`define TCM_CS_DIV8 3'h2
`define TCM_CS_DIV64 3'h3
`define TCM_CS_DIV256 3'h4
`define TCM_CS_DIV1024 3'h5
`define TCM_DIV8_LAST 10'h007
`define TCM_DIV64_LAST 10'h03f
`define TCM_DIV256_LAST 10'h0ff
`define TCM_DIV1024_LAST 10'h3ff
`define TCM_PRE_ZERO 10'h000
`define TCM_PRE_ONE 10'h001
`endif

// file: tcm_timer.v
// 16-bit timer: prescaler, normal and clear-on-match counting, compare output latches
// Summary of operation
// - reset clears each output latch to zero
// - nonzero mode bits route latch to pin
// - pin direction bit still gates the driver
// - software can preset latch before enabling pin
// - mode zero leaves latch unchanged on match
// - new mode acts from next match on
// - force strobe applies action immediately, non-PWM
// - mode bits never affect counting sequence
// - mode bits select set, clear, toggle
// - mode 0 counts up, wraps ffff to 0
// - overflow flag sets when count steps on from ffff
// - overflow flag clears on interrupt execution
// - counter writable any time in normal mode
// - mode 4 clears on A, 12 on capture
// - top sets A match or capture flag
// - top unbuffered; missed match wraps past ffff
// - A toggles each match with mode 1
// - toggle frequency clk over 2N(1+A)
// - prescaler offers 1, 8, 64, 256, 1024
// - clear-on-match mode overflow on max rollover
// - match flag sets next timer cycle
// - forced compare touches latch only
// - counter write blocks next-cycle matches
// - writing one clears flag; interrupt clears too
`timescale 1ns/1ns
`include "tcm_consts.vh"

module tcm_timer #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // configuration
  input wire [3:0] waveformGenMode,
  input wire [2:0] clockSelect,
  input wire [1:0] chanAOutputMode,
  input wire [1:0] chanBOutputMode,
  // counter access
  // a write lands on the next edge and beats a tick in the same cycle
  input wire counterWrite,
  input wire [CNT_W-1:0] counterWriteData,
  output wire [CNT_W-1:0] counterValue,
  // compare and capture values
  // all three are compared live: no shadow copy in these modes
  input wire [CNT_W-1:0] chanACompareValue,
  input wire [CNT_W-1:0] chanBCompareValue,
  input wire [CNT_W-1:0] captureValue,
  // force strobes, one per channel
  // a force outside the non-pwm modes is ignored
  input wire forceA,
  input wire forceB,
  // flag clearing: write-one strobes and interrupt acknowledges
  input wire clearOverflow,
  input wire clearMatchA,
  input wire clearMatchB,
  input wire clearCapture,
  input wire ackOverflow,
  input wire ackMatchA,
  input wire ackMatchB,
  input wire ackCapture,
  // flags
  // each flag stands until a clear or an acknowledge removes it
  output wire overflowFlag,
  output wire chanAMatchFlag,
  output wire chanBMatchFlag,
  output wire captureFlag,
  // port pins for the two compare outputs
  // the enable is the port direction bit, untouched by the timer
  input wire portValueA,
  input wire portValueB,
  input wire chanAPinDirection,
  input wire chanBPinDirection,
  output wire chanAOutputLatch,
  output wire chanBOutputLatch,
  output wire pinOutA,
  output wire pinOutB,
  output wire pinOeA,
  output wire pinOeB
);

  // prescaler state
  reg [9:0] preCnt_ff;
  reg [9:0] nxt_preCnt;
  reg [9:0] preLast;
  reg tick;
  // counter and flags
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] nxt_cnt;
  // flags set by hardware, cleared by software or acknowledge
  reg ovf_ff;
  reg capFlag_ff;
  reg [1:0] matchFlag_ff;
  reg [1:0] ocLatch_ff;
  // one timer cycle of match blocking after a counter write
  reg block_ff;
  // pairs gathered for the per-channel generate
  // mode bits packed two per channel, channel a in the low pair
  wire [3:0] comMode;
  wire [1:0] forceStb;
  wire [1:0] chanMatch;
  wire [1:0] clrMatch;
  wire [CNT_W-1:0] cmpVal [0:1];
  wire nonPwm;
  wire ctcA;
  wire ctcCap;
  wire capMatch;
  wire atMax;
  wire topHit;
  // a real match counts only on a tick with no counter write in play;
  // a write in the same cycle blocks too, since the old count is gone
  wire matchOk;

  // division terminal count per clock select; stop gives no tick
  // the divider restarts from zero on every tick, so a change of select
  // while running can give one short first period; passing through stop
  // always starts a clean count
  always @* begin
    preLast = `TCM_PRE_ZERO;
    tick = 1'b0;
    case (clockSelect)
      `TCM_CS_DIV1: begin
        // undivided: every clock is a timer cycle
        tick = 1'b1;
      end
      `TCM_CS_DIV8: begin
        preLast = `TCM_DIV8_LAST;
        tick = (preCnt_ff >= preLast);
      end
      `TCM_CS_DIV64: begin
        preLast = `TCM_DIV64_LAST;
        tick = (preCnt_ff >= preLast);
      end
      `TCM_CS_DIV256: begin
        preLast = `TCM_DIV256_LAST;
        tick = (preCnt_ff >= preLast);
      end
      `TCM_CS_DIV1024: begin
        preLast = `TCM_DIV1024_LAST;
        tick = (preCnt_ff >= preLast);
      end
      default: begin
        // stop and unused codes, so a stray code never runs the timer
        tick = 1'b0;
      end
    endcase
    // free-running divider; stopped select holds it at zero
    if (clockSelect == `TCM_CS_STOP || tick) begin
      nxt_preCnt = `TCM_PRE_ZERO;
    end else begin
      nxt_preCnt = preCnt_ff + `TCM_PRE_ONE;
    end
  end

  // prescaler register
  // ten bits cover the largest division; smaller ones use the low bits
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_ff <= `TCM_PRE_ZERO;
    end else begin
      preCnt_ff <= nxt_preCnt;
    end
  end

  // mode decode: only the waveform mode bits steer counting
  // pwm codes are not decoded here; they count up with no top and no
  // overflow flag, and force strobes are ignored in them
  assign nonPwm = (waveformGenMode == `TCM_WGM_NORMAL) || ctcA || ctcCap;
  assign ctcA = (waveformGenMode == `TCM_WGM_CTC_A);
  assign ctcCap = (waveformGenMode == `TCM_WGM_CTC_CAP);
  assign capMatch = (cnt_ff == captureValue);
  assign atMax = (cnt_ff == `TCM_CNT_MAX);
  // blocking covers the write cycle and the first tick after it
  assign matchOk = tick && !counterWrite && !block_ff;
  // top compares live registers, so a lowered top is simply missed
  // and the count has to run through ffff and wrap before it matches
  assign topHit = matchOk && ((ctcA && chanMatch[0]) || (ctcCap && capMatch));

  // channel vectors: index 0 is channel a, index 1 is channel b
  assign comMode = {chanBOutputMode, chanAOutputMode};
  assign forceStb = {forceB, forceA};
  // write-one clear and interrupt acknowledge act alike on a flag
  assign clrMatch = {clearMatchB | ackMatchB, clearMatchA | ackMatchA};
  assign cmpVal[0] = chanACompareValue;
  assign cmpVal[1] = chanBCompareValue;

  // next count: software write wins, else step on tick
  // a write is taken even while stopped, and it never raises overflow
  always @* begin
    nxt_cnt = cnt_ff;
    if (counterWrite) begin
      nxt_cnt = counterWriteData;
    end else if (tick) begin
      if (topHit) begin
        nxt_cnt = `TCM_CNT_BOTTOM;
      end else begin
        // mode 0 and a missed top both wrap through ffff
        nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // counter, overflow flag, capture flag, match blocking
  // the overflow flag acts as a seventeenth count bit: counting only
  // ever sets it, software or the interrupt clears it
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= `TCM_CNT_BOTTOM;
      ovf_ff <= 1'b0;
      capFlag_ff <= 1'b0;
      block_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      // block lasts until the next timer tick has passed
      // a write in the cycle of a tick keeps the block for the tick after
      if (counterWrite) begin
        block_ff <= 1'b1;
      end else if (tick) begin
        block_ff <= 1'b0;
      end
      // set beats clear in the same cycle
      // a top hit at ffff in a clear-on-match mode flags overflow as well
      if (tick && nonPwm && atMax && !counterWrite) begin
        ovf_ff <= 1'b1;
      end else if (clearOverflow || ackOverflow) begin
        ovf_ff <= 1'b0;
      end
      // no capture unit here: only a capture-register top hit sets it
      if (tick && ctcCap && topHit) begin
        capFlag_ff <= 1'b1;
      end else if (clearCapture || ackCapture) begin
        capFlag_ff <= 1'b0;
      end
    end
  end

  // per-channel compare, flag and output latch
  // each channel owns its own bits of the flag and latch vectors, so
  // no bit has more than one driver
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      reg latchNext;
      assign chanMatch[ch] = (cnt_ff == cmpVal[ch]);
      // action computed from current mode bits, so changes hit next match
      // force and match share this action, so both obey the same mode
      always @* begin
        case (comMode[ch*2 +: 2])
          `TCM_COM_TOGGLE: begin
            latchNext = ~ocLatch_ff[ch];
          end
          `TCM_COM_CLEAR: begin
            latchNext = 1'b0;
          end
          `TCM_COM_SET: begin
            latchNext = 1'b1;
          end
          default: begin
            // mode zero: no action, the latch holds
            latchNext = ocLatch_ff[ch];
          end
        endcase
      end
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          matchFlag_ff[ch] <= 1'b0;
          ocLatch_ff[ch] <= 1'b0;
        end else begin
          // flag set on the tick that sees equality; set wins over clear
          if (matchOk && chanMatch[ch]) begin
            matchFlag_ff[ch] <= 1'b1;
          end else if (clrMatch[ch]) begin
            matchFlag_ff[ch] <= 1'b0;
          end
          // force acts at once and touches neither flag nor counter
          // forcing is also how software presets the pin before enabling it
          if (forceStb[ch] && nonPwm) begin
            ocLatch_ff[ch] <= latchNext;
          end else if (matchOk && chanMatch[ch]) begin
            // toggling on each top hit gives a period of two top cycles
            ocLatch_ff[ch] <= latchNext;
          end
        end
      end
    end
  endgenerate

  // outputs
  // flags and latches come straight from flip-flops
  assign counterValue = cnt_ff;
  assign overflowFlag = ovf_ff;
  assign chanAMatchFlag = matchFlag_ff[0];
  assign chanBMatchFlag = matchFlag_ff[1];
  assign captureFlag = capFlag_ff;
  assign chanAOutputLatch = ocLatch_ff[0];
  assign chanBOutputLatch = ocLatch_ff[1];
  // override source only; direction stays with the port bit
  assign pinOutA = (chanAOutputMode != `TCM_COM_NONE) ? ocLatch_ff[0] : portValueA;
  assign pinOutB = (chanBOutputMode != `TCM_COM_NONE) ? ocLatch_ff[1] : portValueB;
  assign pinOeA = chanAPinDirection;
  assign pinOeB = chanBPinDirection;

endmodule

// file: tcm_pin_load.sv
// far-side load on a compare output pin
`timescale 1ns/1ns
module tcm_pin_load (
  // pin as the timer drives it
  input wire pinOut,
  input wire pinOe,
  // level on the board wire
  output wire pinLevel
);
  // released line rests at the pull-up, never at a stale value
  assign pinLevel = pinOe ? pinOut : 1'h1;
endmodule

// file: tcm_timer_properties.sv
// checker: port timing relations of the timer
`timescale 1ns/1ns
module tcm_timer_chk #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // controls
  input wire [3:0] waveformGenMode,
  input wire [1:0] chanAOutputMode,
  input wire counterWrite,
  input wire [CNT_W-1:0] counterWriteData,
  input wire [CNT_W-1:0] chanACompareValue,
  input wire forceA,
  input wire clearMatchA,
  input wire ackMatchA,
  input wire portValueA,
  input wire chanAPinDirection,
  // outputs
  input wire [CNT_W-1:0] counterValue,
  input wire overflowFlag,
  input wire chanAMatchFlag,
  input wire chanAOutputLatch,
  input wire pinOutA,
  input wire pinOeA
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  reset_clear_a: assert property ($rose(reset_n) |-> !chanAOutputLatch)
    else $error("latch not zero after reset");
  pin_select_a: assert property (pinOutA ==
    (chanAOutputMode != 2'h0 ? chanAOutputLatch : portValueA)) else $error("pin source wrong");
  pin_dir_a: assert property (pinOeA == chanAPinDirection)
    else $error("pin enable wrong");
  mode_none_a: assert property (chanAOutputMode == 2'h0 |=> $stable(chanAOutputLatch))
    else $error("latch moved with mode zero");
  latch_cause_a: assert property ($changed(chanAOutputLatch) |-> $past(forceA) ||
    $past(counterValue) == $past(chanACompareValue)) else $error("latch moved without cause");
  latch_action_a: assert property ($changed(chanAOutputLatch) |->
    $past(chanAOutputMode) == 2'h1 || $past(chanAOutputMode) == {1'h1, chanAOutputLatch})
    else $error("wrong latch action");
  count_step_a: assert property (!counterWrite ##1 $changed(counterValue) |->
    counterValue == $past(counterValue) + 16'h1 || counterValue == 16'h0) else $error("bad step");
  ovf_wrap_a: assert property (counterValue == 16'hffff && !counterWrite &&
    waveformGenMode[1:0] == 2'h0 ##1 counterValue == 16'h0 |-> overflowFlag)
    else $error("no overflow flag");
  write_load_a: assert property (counterWrite |=> counterValue == $past(counterWriteData))
    else $error("counter write lost");
  write_block_a: assert property (counterWrite && !chanAMatchFlag |=> !chanAMatchFlag)
    else $error("match not blocked");
  flag_cause_a: assert property ($rose(chanAMatchFlag) |->
    $past(counterValue) == $past(chanACompareValue)) else $error("flag without match");
  flag_clear_a: assert property ((clearMatchA || ackMatchA) &&
    counterValue != chanACompareValue |=> !chanAMatchFlag) else $error("flag not cleared");
  cover property (waveformGenMode == 4'h4 && $rose(chanAMatchFlag));
  cover property ($rose(overflowFlag));
  cover property (forceA && chanAOutputMode == 2'h1);
endmodule
bind tcm_timer tcm_timer_chk #(.CNT_W(CNT_W)) u_chk (.*);

// file: tb_tcm_timer.sv
// testbench: random stimulus checked against a cycle model
`timescale 1ns/1ns
module tb_tcm_timer;
  // stimulus
  reg ref_clk = '0, reset_n = '0;
  reg [3:0] waveformGenMode = '0;
  reg [2:0] clockSelect = '0;
  reg [1:0] chanAOutputMode = '0, chanBOutputMode = '0;
  reg [15:0] counterWriteData = '0, chanACompareValue = '0, chanBCompareValue = '0;
  reg [15:0] captureValue = '0;
  reg counterWrite = '0, forceA = '0, forceB = '0, portValueA = '0, portValueB = '0;
  reg clearOverflow = '0, clearMatchA = '0, clearMatchB = '0, clearCapture = '0;
  reg ackOverflow = '0, ackMatchA = '0, ackMatchB = '0, ackCapture = '0;
  reg chanAPinDirection = '0, chanBPinDirection = '0;
  // observed
  wire [15:0] counterValue;
  wire overflowFlag, chanAMatchFlag, chanBMatchFlag, captureFlag, pinLevelA;
  wire chanAOutputLatch, chanBOutputLatch, pinOutA, pinOutB, pinOeA, pinOeB;
  // model state, bookkeeping
  integer mc, pre, ph, fails = 0, checks = 0, seed = 92;
  reg [31:0] r, q;
  reg [15:0] top;
  reg st, tk, ok, hit, ma, mb, blk, fo, fa, fb, fc, la, lb;
  always #10 ref_clk = ~ref_clk;
  tcm_timer DUT (.*);
  tcm_pin_load LOADA (.pinOut(pinOutA), .pinOe(pinOeA), .pinLevel(pinLevelA));
  // prescaler mask per clock select
  function integer msk(input [2:0] c);
    msk = c == 3'h1 ? 0 : c == 3'h2 ? 7 : c == 3'h3 ? 63 : c == 3'h4 ? 255 : 1023;
  endfunction
  // latch action of a mode on an event
  function act(input [1:0] m, input l, input e);
    act = !e || m == 2'h0 ? l : m == 2'h1 ? !l : m[0];
  endfunction
  // cycle model, reads inputs before the bench updates them
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {mc, pre, blk, fo, fa, fb, fc, la, lb} = '0;
    end else begin
      st = clockSelect == 3'h0 || clockSelect > 3'h5;
      tk = !st && (pre & msk(clockSelect)) == msk(clockSelect);
      pre = st ? 0 : pre + 1;
      ok = tk && !(counterWrite || blk);
      top = waveformGenMode == 4'h4 ? chanACompareValue : captureValue;
      hit = ok && waveformGenMode[2] && mc == top;
      ma = ok && mc == chanACompareValue;
      mb = ok && mc == chanBCompareValue;
      fo = tk && mc == 65535 && !counterWrite || fo && !(clearOverflow || ackOverflow);
      fa = ma || fa && !(clearMatchA || ackMatchA);
      fb = mb || fb && !(clearMatchB || ackMatchB);
      fc = hit && waveformGenMode[3] || fc && !(clearCapture || ackCapture);
      la = act(chanAOutputMode, la, forceA || ma);
      lb = act(chanBOutputMode, lb, forceB || mb);
      mc = counterWrite ? counterWriteData : !tk ? mc : hit ? 0 : (mc + 1) % 65536;
      blk = counterWrite || blk && !tk;
    end
  end
  // compare every cycle at the falling edge
  always @(negedge ref_clk) if (reset_n) begin
    chk("counterValue", counterValue, mc[15:0]);
    chk("overflowFlag", overflowFlag, fo);
    chk("chanAMatchFlag", chanAMatchFlag, fa);
    chk("chanBMatchFlag", chanBMatchFlag, fb);
    chk("captureFlag", captureFlag, fc);
    chk("chanAOutputLatch", chanAOutputLatch, la);
    chk("chanBOutputLatch", chanBOutputLatch, lb);
    chk("pinLevelA", pinLevelA, !chanAPinDirection | (chanAOutputMode ? la : portValueA));
    chk("pinOutA", pinOutA, chanAOutputMode ? la : portValueA);
    chk("pinOutB", pinOutB, chanBOutputMode ? lb : portValueB);
    chk("pinOeA", pinOeA, chanAPinDirection);
    chk("pinOeB", pinOeB, chanBPinDirection);
  end
  task chk(input [127:0] n, input [15:0] s, input [15:0] e);
    checks = checks + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("Error %0s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // phases: stop and each divider, modes 0/4/12, one reset in mid-run
  initial begin
    repeat (3) @(posedge ref_clk);
    for (ph = 0; ph < 12; ph = ph + 1) begin
      @(posedge ref_clk);
      clockSelect <= 3'h0;
      reset_n <= ph != 6;
      waveformGenMode <= {ph % 3 == 2, ph % 3 != 0, 2'h0};
      repeat (2500) begin
        @(posedge ref_clk);
        r = $random(seed);
        q = $random(seed);
        reset_n <= 1'h1;
        clockSelect <= 3'(ph % 6);
        counterWrite <= r[3:0] == 4'h0;
        counterWriteData <= {{12{r[4]}}, r[8:5]};
        {chanAOutputMode, chanBOutputMode} <= r[12:9];
        forceA <= r[15:13] == 3'h0;
        forceB <= r[18:16] == 3'h0;
        {clearOverflow, clearMatchA, clearMatchB, clearCapture} <= r[22:19] & r[26:23] & r[30:27];
        {ackOverflow, ackMatchA, ackMatchB, ackCapture} <= q[3:0] & q[7:4] & q[11:8];
        {portValueA, portValueB, chanAPinDirection, chanBPinDirection} <= q[15:12];
        // rare top changes, often below the count
        if (q[20:16] == 5'h0) begin
          {chanACompareValue, chanBCompareValue} <= {12'h0, q[24:21], 12'h0, q[28:25]};
          captureValue <= {12'h0, q[31:29], r[31]};
        end
      end
    end
    print_verdict;
  end
  // hang guard, well past the planned run
  initial begin
    #700000;
    fails = fails + 1;
    print_verdict;
  end
endmodule
